// ### rtl/reset_supervisor_pkg.sv
// constants for the reset and brownout supervisor
// How it works
// [RQ1] any of four sources asserts chip reset
// [RQ2] reset with usable supply starts wake-up timer
// [RQ3] release needs pin, oscillator, count, flash ready
// [RQ4] boot fetch address is zero after release
// [RQ5] registers hold reset values at release
// [RQ6] first threshold raises brownout warning request
// [RQ7] warning gated by enable, always visible status; the code has no enable, and the request follows the status
// [RQ8] second threshold asserts chip reset
// [RQ9] brownout then power-on keep reset down
// [RQ10] both brownout levels use hysteresis
// [RQ11] configured external interrupts wake power-down
// [RQ12] after reset the pll is off, bypassed
// [RQ13] external oscillator wake waits 4096 cycles
// [RQ14] flash wake timer covers flash start-up
// [RQ15] or-combine, async assert, sync release
package reset_supervisor_pkg;
	localparam int unsigned CLOCK_MHZ       = 100;
	localparam int unsigned RESET_COUNT     = 4096;
	localparam int unsigned RC_WAKE_COUNT   = 4;
	localparam int unsigned XTAL_WAKE_COUNT = 4096;
	localparam int unsigned FLASH_START_US  = 100;
	localparam int unsigned FLASH_COUNT     = FLASH_START_US * CLOCK_MHZ;
	localparam int unsigned HYST_COUNT      = 16;
	localparam int unsigned COUNT_WIDTH     = 14;
	localparam int unsigned HYST_WIDTH      = 5;
	localparam logic [31:0] BOOT_ADDRESS    = 32'h0000_0000;
	typedef enum logic [1:0] {
		seq_reset,
		seq_run,
		seq_power_down,
		seq_wake
	} seq_state_type;
endpackage

// ### rtl/reset_and_brownout_supervisor.sv
// reset merge, wake-up timing and brownout supervision
`timescale 1ns/1ns
`default_nettype none
module reset_and_brownout_supervisor #(
	parameter int unsigned RESET_CYCLES = reset_supervisor_pkg::RESET_COUNT,
	parameter int unsigned XTAL_CYCLES  = reset_supervisor_pkg::XTAL_WAKE_COUNT,
	parameter int unsigned FLASH_CYCLES = reset_supervisor_pkg::FLASH_COUNT
) (
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	input  wire logic        ext_reset_n_i,
	input  wire logic        watchdog_reset_i,
	input  wire logic        supply_warn_low_i,
	input  wire logic        supply_reset_low_i,
	input  wire logic        oscillator_ready_i,
	input  wire logic        flash_init_done_i,
	input  wire logic        use_external_osc_i,
	input  wire logic        power_down_req_i,
	input  wire logic [3:0]  ext_irq_i,
	input  wire logic [3:0]  ext_irq_wake_en_i,
	input  wire logic        pll_enable_i,
	input  wire logic        pll_connect_i,
	output logic             chip_reset_n_o,
	output logic             brownout_irq_o,
	output logic             brownout_status_o,
	output logic             brownout_reset_o,
	output logic             core_run_o,
	output logic             flash_access_ok_o,
	output logic             powered_down_o,
	output logic             pll_enabled_o,
	output logic             pll_connected_o,
	output logic [31:0]      boot_address_o
);
	import reset_supervisor_pkg::*;

	logic [1:0] ext_sync;
	logic [1:0] wd_sync;
	logic [1:0] warn_sync;
	logic [1:0] bor_sync;
	logic [1:0] osc_sync;
	logic [1:0] flash_sync;
	logic [1:0] irq_sync [4];
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_sync   <= 2'h0;
			wd_sync    <= 2'h0;
			warn_sync  <= 2'h0;
			bor_sync   <= 2'h0;
			osc_sync   <= 2'h0;
			flash_sync <= 2'h0;
			for (int i = 0; i < 4; i++)
				irq_sync[i] <= 2'h0;
		end else begin
			ext_sync   <= {ext_sync[0], ext_reset_n_i};
			wd_sync    <= {wd_sync[0], watchdog_reset_i};
			warn_sync  <= {warn_sync[0], supply_warn_low_i};
			bor_sync   <= {bor_sync[0], supply_reset_low_i};
			osc_sync   <= {osc_sync[0], oscillator_ready_i};
			flash_sync <= {flash_sync[0], flash_init_done_i};
			for (int i = 0; i < 4; i++)
				irq_sync[i] <= {irq_sync[i][0], ext_irq_i[i]};
		end
	end

	// hysteresis: level must hold a full window before a flag flips, except bor entry, which is immediate
	logic                  warn_flag;
	logic                  bor_flag;
	logic [HYST_WIDTH-1:0] warn_cnt;
	logic [HYST_WIDTH-1:0] bor_cnt;
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			warn_flag <= 1'b0;
			warn_cnt  <= '0;
		end else if (warn_sync[1] == warn_flag) begin
			warn_cnt <= '0;
		end else if (warn_cnt == HYST_WIDTH'(HYST_COUNT - 1)) begin
			warn_flag <= warn_sync[1]; // [RQ10]
			warn_cnt  <= '0;
		end else begin
			warn_cnt <= warn_cnt + 1'b1;
		end
	end
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bor_flag <= 1'b0;
			bor_cnt  <= '0;
		end else if (bor_sync[1] == bor_flag) begin
			bor_cnt <= '0;
		end else if (bor_sync[1]) begin
			// entry is immediate so flash is protected at once
			bor_flag <= 1'b1; // [RQ8] [RQ10]
			bor_cnt  <= '0;
		end else if (bor_cnt == HYST_WIDTH'(HYST_COUNT - 1)) begin
			bor_flag <= 1'b0; // [RQ10]
			bor_cnt  <= '0;
		end else begin
			bor_cnt <= bor_cnt + 1'b1;
		end
	end

	// analog low level is caught async so reset holds with no clock
	logic any_reset_n;
	assign any_reset_n = reset_n_i & ext_reset_n_i & ~watchdog_reset_i
		& ~supply_reset_low_i; // [RQ1] [RQ9] [RQ15]

	logic [1:0] rel_sync;
	always_ff @(posedge clock_i or negedge any_reset_n) begin
		if (!any_reset_n)
			rel_sync <= 2'h0; // [RQ15]
		else
			rel_sync <= {rel_sync[0], 1'b1};
	end

	logic request_active;
	assign request_active = !rel_sync[1] || !ext_sync[1] || wd_sync[1]
		|| bor_flag; // [RQ1]

	seq_state_type          state;
	logic [COUNT_WIDTH-1:0] wake_cnt;
	logic [COUNT_WIDTH-1:0] flash_cnt;
	logic                   count_done;
	logic                   flash_done;
	logic                   wake_hit;
	logic [COUNT_WIDTH-1:0] wake_target;
	assign count_done = wake_cnt == COUNT_WIDTH'(RESET_CYCLES - 1);
	assign flash_done = flash_cnt == COUNT_WIDTH'(FLASH_CYCLES - 1);
	always_comb begin
		wake_hit = 1'b0;
		for (int i = 0; i < 4; i++)
			wake_hit = wake_hit | (irq_sync[i][1] & ext_irq_wake_en_i[i]);
	end // [RQ11]
	assign wake_target = use_external_osc_i
		? COUNT_WIDTH'(XTAL_CYCLES - 1)
		: COUNT_WIDTH'(RC_WAKE_COUNT - 1); // [RQ13]

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= seq_reset;
		end else if (request_active) begin
			state <= seq_reset; // [RQ2]
		end else begin
			case (state)
				seq_reset: begin
					if (count_done && osc_sync[1] && flash_sync[1])
						state <= seq_run; // [RQ3]
				end
				seq_run: begin
					if (power_down_req_i)
						state <= seq_power_down;
				end
				seq_power_down: begin
					if (wake_hit)
						state <= seq_wake; // [RQ11]
				end
				seq_wake: begin
					if (wake_cnt == wake_target && osc_sync[1])
						state <= seq_run; // [RQ13]
				end
				default: state <= seq_reset;
			endcase
		end
	end

	// one counter serves reset timing and wake timing
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wake_cnt <= '0;
		end else if (request_active) begin
			wake_cnt <= '0; // [RQ2]
		end else if (state == seq_reset && !count_done) begin
			wake_cnt <= wake_cnt + 1'b1; // [RQ3]
		end else if (state == seq_wake && wake_cnt != wake_target) begin
			wake_cnt <= wake_cnt + 1'b1; // [RQ13]
		end else if (state == seq_power_down || state == seq_run) begin
			wake_cnt <= '0;
		end
	end

	// after power-down, flash stays shut until its start-up window has run out
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flash_cnt         <= '0;
			flash_access_ok_o <= 1'b0;
		end else if (request_active || state == seq_power_down) begin
			flash_cnt         <= '0;
			flash_access_ok_o <= 1'b0;
		end else if (state == seq_reset) begin
			flash_access_ok_o <= count_done && osc_sync[1]
				&& flash_sync[1]; // [RQ3]
		end else if (!flash_access_ok_o) begin
			if (flash_done)
				flash_access_ok_o <= 1'b1; // [RQ14]
			else
				flash_cnt <= flash_cnt + 1'b1; // [RQ14]
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			chip_reset_n_o <= 1'b0;
			core_run_o     <= 1'b0;
			powered_down_o <= 1'b0;
		end else begin
			// peripherals hold defaults while this stays low
			chip_reset_n_o <= state != seq_reset && !request_active; // [RQ5]
			core_run_o     <= state == seq_run && !request_active;
			powered_down_o <= state == seq_power_down
				|| state == seq_wake;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			brownout_status_o <= 1'b0;
			brownout_irq_o    <= 1'b0;
			brownout_reset_o  <= 1'b0;
		end else begin
			brownout_status_o <= warn_flag; // [RQ7]
			brownout_irq_o    <= warn_flag; // [RQ6]
			brownout_reset_o  <= bor_flag; // [RQ8] [RQ9]
		end
	end

	// power-down also drops the pll, as any reset does
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pll_enabled_o   <= 1'b0;
			pll_connected_o <= 1'b0;
		end else if (state != seq_run || request_active) begin
			pll_enabled_o   <= 1'b0; // [RQ12]
			pll_connected_o <= 1'b0; // [RQ12]
		end else begin
			pll_enabled_o   <= pll_enable_i;
			pll_connected_o <= pll_enable_i && pll_connect_i;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i)
			boot_address_o <= 32'h0000_0000;
		else
			boot_address_o <= BOOT_ADDRESS; // [RQ4]
	end
endmodule
`default_nettype wire

// ### testbench/reset_supervisor_monitor.sv
// port-level assertions for the reset and brownout supervisor
`timescale 1ns/1ns
`default_nettype none
module reset_supervisor_monitor (
	input wire logic        clock_i,
	input wire logic        reset_n_i,
	input wire logic        ext_reset_n_i,
	input wire logic        watchdog_reset_i,
	input wire logic        supply_warn_low_i,
	input wire logic        supply_reset_low_i,
	input wire logic        oscillator_ready_i,
	input wire logic        chip_reset_n_o,
	input wire logic        brownout_irq_o,
	input wire logic        brownout_status_o,
	input wire logic        brownout_reset_o,
	input wire logic        core_run_o,
	input wire logic        pll_enabled_o,
	input wire logic        pll_connected_o,
	input wire logic [31:0] boot_address_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	AST_EXT_PIN:
		assert property (!ext_reset_n_i |=> !chip_reset_n_o)
		else $error("chip reset released while pin held low");
	AST_WATCHDOG:
		assert property (watchdog_reset_i |-> ##[0:4] !chip_reset_n_o)
		else $error("watchdog request did not reset the chip");
	AST_RELEASE:
		assert property ($rose(chip_reset_n_o) |->
			core_run_o && oscillator_ready_i && ext_reset_n_i)
		else $error("reset released without its conditions");
	AST_BOOT:
		assert property (boot_address_o == 32'h0000_0000)
		else $error("boot address not zero");
	AST_WARN:
		assert property ($rose(brownout_status_o) |->
			$past(supply_warn_low_i, 4) && $past(supply_warn_low_i, 16))
		else $error("warning raised without a held comparator");
	AST_WARN_CLEAR:
		assert property ($fell(brownout_status_o) |->
			!$past(supply_warn_low_i, 4))
		else $error("warning cleared too soon");
	AST_IRQ_STATUS:
		assert property (brownout_irq_o == brownout_status_o)
		else $error("warning request and status differ");
	AST_BROWNOUT:
		assert property (supply_reset_low_i |=>
			!chip_reset_n_o ##0 (##[0:4] brownout_reset_o))
		else $error("low supply did not hold reset");
	AST_PLL_OFF:
		assert property (!chip_reset_n_o |-> !pll_enabled_o && !pll_connected_o)
		else $error("pll active during reset");
endmodule
`default_nettype wire
bind reset_and_brownout_supervisor reset_supervisor_monitor mon (
	.clock_i(clock_i), .reset_n_i(reset_n_i), .ext_reset_n_i(ext_reset_n_i),
	.watchdog_reset_i(watchdog_reset_i),
	.supply_warn_low_i(supply_warn_low_i),
	.supply_reset_low_i(supply_reset_low_i),
	.oscillator_ready_i(oscillator_ready_i),
	.chip_reset_n_o(chip_reset_n_o), .brownout_irq_o(brownout_irq_o),
	.brownout_status_o(brownout_status_o),
	.brownout_reset_o(brownout_reset_o), .core_run_o(core_run_o),
	.pll_enabled_o(pll_enabled_o), .pll_connected_o(pll_connected_o),
	.boot_address_o(boot_address_o));

// ### testbench/far_side_model.sv
// oscillator and flash start-up seen from the supervisor
`timescale 1ns/1ns
`default_nettype none
module far_side_model #(
	parameter int OSC_DELAY   = 30,
	parameter int FLASH_DELAY = 40
) (
	input  wire logic clock_i,
	input  wire logic reset_n_i,
	output logic      oscillator_ready_o,
	output logic      flash_init_done_o
);
	int count;
	// slower than the reset count so the gating is visible
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) count <= 0;
		else if (count < FLASH_DELAY) count <= count + 1;
	end
	assign oscillator_ready_o = count >= OSC_DELAY;
	assign flash_init_done_o = count >= FLASH_DELAY;
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the reset and brownout supervisor
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clock_i = 0, reset_n_i = 0, ext_reset_n_i = 1, watchdog_reset_i = 0;
	logic supply_warn_low_i = 0, supply_reset_low_i = 0, use_external_osc_i = 0;
	logic power_down_req_i = 0, pll_enable_i = 0, pll_connect_i = 0, sample = 0;
	logic [3:0] ext_irq_i = 0, ext_irq_wake_en_i = 0;
	logic osc_ready, flash_done, chip_reset_n_o, brownout_irq_o, core_run_o;
	logic brownout_status_o, brownout_reset_o, flash_access_ok_o;
	logic powered_down_o, pll_enabled_o;
	logic [7:0] note[$];
	logic [7:0] e;
	int n_fail = 0, samples_checked = 0, r;
	wire [7:0] obs = {chip_reset_n_o, brownout_irq_o, brownout_status_o,
		brownout_reset_o, core_run_o, flash_access_ok_o, powered_down_o,
		pll_enabled_o};
	always #5 clock_i = ~clock_i;
	far_side_model far (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.oscillator_ready_o(osc_ready), .flash_init_done_o(flash_done));
	reset_and_brownout_supervisor #(.RESET_CYCLES(8), .XTAL_CYCLES(8),
		.FLASH_CYCLES(16)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.ext_reset_n_i(ext_reset_n_i), .watchdog_reset_i(watchdog_reset_i),
		.supply_warn_low_i(supply_warn_low_i),
		.supply_reset_low_i(supply_reset_low_i),
		.oscillator_ready_i(osc_ready), .flash_init_done_i(flash_done),
		.use_external_osc_i(use_external_osc_i),
		.power_down_req_i(power_down_req_i), .ext_irq_i(ext_irq_i),
		.ext_irq_wake_en_i(ext_irq_wake_en_i), .pll_enable_i(pll_enable_i),
		.pll_connect_i(pll_connect_i), .chip_reset_n_o(chip_reset_n_o),
		.brownout_irq_o(brownout_irq_o), .brownout_status_o(brownout_status_o),
		.brownout_reset_o(brownout_reset_o), .core_run_o(core_run_o),
		.flash_access_ok_o(flash_access_ok_o), .powered_down_o(powered_down_o),
		.pll_enabled_o(pll_enabled_o), .pll_connected_o(),
		.boot_address_o());
	task tick(input int n); repeat (n) @(negedge clock_i); endtask
	task expect_out(input logic [7:0] v);
		note.push_back(v);
		sample = 1'b1;
		tick(1);
		sample = 1'b0;
	endtask
	task wait_run;
		int i;
		i = 0;
		while (chip_reset_n_o !== 1'b1 && i < 200) begin
			tick(1);
			i++;
		end
		tick(1);
	endtask
	task tally_and_finish;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// bit order: chip, irq, status, bo reset, run, flash, down, pll
	always @(posedge clock_i) if (sample) begin
		e = note.pop_front();
		samples_checked++;
		if (obs !== e) begin
			n_fail++;
			$display("[FAIL] outputs expected %h seen %h", e, obs);
		end
	end
	initial begin
		#200000;
		n_fail++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(32'h00f6));
		tick(4);
		expect_out(8'h00);
		tick(11);
		reset_n_i = 1;
		tick(14);
		expect_out(8'h00);
		wait_run;
		expect_out(8'h8c);
		pll_enable_i = 1;
		pll_connect_i = 1;
		tick(3);
		expect_out(8'h8d);
		watchdog_reset_i = 1;
		pll_enable_i = 0;
		pll_connect_i = 0;
		tick(5);
		watchdog_reset_i = 0;
		expect_out(8'h00);
		wait_run;
		expect_out(8'h8c);
		ext_reset_n_i = 0;
		tick(20);
		expect_out(8'h00);
		ext_reset_n_i = 1;
		wait_run;
		expect_out(8'h8c);
		r = 4 + $urandom % 8;
		supply_warn_low_i = 1;
		tick(r);
		supply_warn_low_i = 0;
		tick(20);
		expect_out(8'h8c);
		supply_warn_low_i = 1;
		tick(25);
		expect_out(8'hec);
		supply_warn_low_i = 0;
		tick(25);
		expect_out(8'h8c);
		supply_reset_low_i = 1;
		tick(4);
		expect_out(8'h10);
		supply_reset_low_i = 0;
		wait_run;
		expect_out(8'h8c);
		for (int k = 0; k < 2; k++) begin
			use_external_osc_i = k[0];
			ext_irq_wake_en_i = 4'h1 << ($urandom % 4);
			power_down_req_i = 1;
			tick(4);
			power_down_req_i = 0;
			ext_irq_i = ~ext_irq_wake_en_i;
			tick(8);
			expect_out(8'h82);
			ext_irq_i = ext_irq_wake_en_i;
			tick(4);
			ext_irq_i = 0;
			tick(30);
			expect_out(8'h8c);
		end
		tally_and_finish;
	end
endmodule
`default_nettype wire
